// ===== phy_cfg_map.svh
`ifndef PHY_CFG_MAP_SVH
`define PHY_CFG_MAP_SVH
`define ADDR_CONFIG_TWO 32'h0000_0050
`define ADDR_RX_ERR_COUNT 32'h0000_0054
`define ADDR_SELF_TEST 32'h0000_0058
`define IDX_CONFIG_TWO 16'h0014
`define IDX_RX_ERR_COUNT 16'h0015
`define IDX_SELF_TEST 16'h0016
`define CFG_INT_POL_BIT 13
`define CFG_RETRY_HI 11
`define CFG_RETRY_LO 10
`define CFG_DS_EN_BIT 9
`define CFG_ENERGY_BIT 8
`define CFG_TEN_BIT 6
`define CFG_RETRY_RESET 2'h2
`define CFG_LOW_PATTERN 6'h07
`define ST_WRAP_BIT 15
`define ST_PAYLOAD_BIT 14
`define ST_SHORT_BIT 13
`define ST_GEN_EN_BIT 12
`define ST_FAR_FWD_BIT 7
`define ST_MII_FWD_BIT 6
`define ST_LOOP_HI 5
`define ST_LOOP_LO 2
`define ST_CODING_HI 1
`define ST_CODING_LO 0
`define ST_WRITE_MASK 16'hf0ff
`define CFG_WRITE_MASK 16'h2340
`define LOOP_REVERSE 4'h8
`define LOOP_EXTERNAL 4'h4
`define LOOP_ANALOG 4'h2
`define LOOP_DIGITAL 4'h1
`define SHORT_FRAME_BYTES 11'h040
`define LONG_FRAME_BYTES 11'h5ee
`define ERR_TALLY_MAX 16'hffff
`endif

// ===== phy_cfg_pkg.sv
package phy_cfg_pkg;
  typedef enum logic [1:0] {SPEED_1000, SPEED_100, SPEED_10} link_speed_t;
  typedef enum logic [2:0] {CODE_OFF, CODE_BEFORE_SCR, CODE_AFTER_SCR, CODE_AFTER_MLT3, CODE_GIG_EARLY}
    coding_point_t;
  typedef enum {GEN_IDLE, GEN_RUN} gen_state_t;
endpackage

// ===== frame_generator.sv
`timescale 1ns/1ps
`include "phy_cfg_map.svh"
module frame_generator
  import phy_cfg_pkg::*;
#(
  parameter int CNT_W = 16
)(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic payload_prbs_i,
  input wire logic short_i,
  input wire logic wrap_mode_i,
  input wire logic byte_ready_i,
  output logic byte_valid_o,
  output logic [7:0] byte_data_o,
  output logic busy_o,
  output logic wrap_pulse_o
);
  gen_state_t state_reg;
  logic [10:0] pos_reg;
  logic [15:0] lfsr_reg;
  logic [CNT_W-1:0] frame_cnt_reg;
  logic single_done_reg;
  logic [10:0] last_pos;
  logic step;

  assign last_pos = short_i ? `SHORT_FRAME_BYTES - 11'h001 : `LONG_FRAME_BYTES - 11'h001;
  assign step = (state_reg == GEN_RUN) && byte_ready_i;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= GEN_IDLE;
      pos_reg <= 11'h000;
      single_done_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        GEN_IDLE:
        begin
          pos_reg <= 11'h000;
          if (!enable_i)
            single_done_reg <= 1'b0;
          else if (payload_prbs_i || !single_done_reg)
            state_reg <= GEN_RUN;
        end
        GEN_RUN:
        begin
          if (!enable_i)
            state_reg <= GEN_IDLE;
          else if (step)
          begin
            if (pos_reg == last_pos)
            begin
              pos_reg <= 11'h000;
              if (!payload_prbs_i)
              begin
                single_done_reg <= 1'b1;
                state_reg <= GEN_IDLE;
              end
            end
            else
              pos_reg <= pos_reg + 11'h001;
          end
        end
        default: state_reg <= GEN_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      lfsr_reg <= 16'hffff;
    else if (step && payload_prbs_i)
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[14] ^ lfsr_reg[12] ^ lfsr_reg[3]};
  end

  // Frame counter wraps with a pulse in continuous mode
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      frame_cnt_reg <= '0;
      wrap_pulse_o <= 1'b0;
    end
    else
    begin
      wrap_pulse_o <= 1'b0;
      if (step && pos_reg == last_pos && payload_prbs_i)
      begin
        if (&frame_cnt_reg)
        begin
          if (wrap_mode_i)
          begin
            frame_cnt_reg <= '0;
            wrap_pulse_o <= 1'b1;
          end
        end
        else
          frame_cnt_reg <= frame_cnt_reg + 1'b1;
      end
    end
  end

  assign byte_valid_o = state_reg == GEN_RUN;
  assign byte_data_o = payload_prbs_i ? lfsr_reg[7:0] : 8'h55;
  assign busy_o = state_reg == GEN_RUN;
endmodule // frame_generator

// ===== phy_config_bist_registers.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "phy_cfg_map.svh"
// What this block does
// - Interrupt pin polarity follows polarity bit
// - Downshift after coded count of gigabit failures
// - Downshift only while enable bit set
// - Energy mode downshifts on silent pairs C,D
// - Ten-megabit fallback only while bit set
// - Saturating sixteen-bit receive error tally
// - Any write to the tally address clears the error tally
// - Reserved bits ignore writes, read fixed
// - Continuous mode wraps the frame counter with pulse
// - PRBS payload sends frames endlessly; checker stays
// - Constant payload sends one frame only
// - Short bit picks 64 or 1518 bytes
// - Generator runs only while enabled
// - Reverse loop forwards to MAC when set
// - MII loop transmits to line when set
// - One-hot field selects loopback point
// - Fast Ethernet coding loop point by code
// - Gigabit coding loop when low bit set
module phy_config_bist_registers
  import phy_cfg_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b0
)(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic downshift_strap_i,
  input wire logic event_pending_i,
  input wire logic rx_error_event_i,
  input wire logic gig_attempt_fail_i,
  input wire logic fast_attempt_fail_i,
  input wire logic energy_cd_absent_i,
  input wire logic [1:0] link_speed_i,
  input wire logic loop_active_i,
  input wire logic frame_ready_i,
  output logic int_pin_o,
  output logic downshift_to_fast_o,
  output logic downshift_to_ten_o,
  output logic frame_valid_o,
  output logic [7:0] frame_data_o,
  output logic generator_busy_o,
  output logic prbs_checker_on_o,
  output logic prbs_wrap_pulse_o,
  output logic [3:0] loop_point_o,
  output logic [2:0] coding_point_o,
  output logic rx_to_mac_o,
  output logic tx_to_line_o
);
  logic int_active_low_reg;
  logic [1:0] downshift_retry_count_reg;
  logic downshift_enable_reg;
  logic downshift_energy_mode_reg;
  logic downshift_to_ten_enable_reg;
  logic [15:0] receive_error_tally_reg;
  logic [15:0] self_test_reg;
  logic [3:0] fail_cnt_reg;
  logic strap_taken_reg;
  logic wr_fire;
  logic rd_fire;
  logic bad_addr;
  logic [3:0] fail_limit;
  logic gen_valid;
  logic [7:0] gen_data;
  logic gen_busy;
  logic gen_wrap;
  logic [15:0] cfg_view;

  function automatic logic [3:0] retry_limit(input logic [1:0] code);
    case (code)
      2'h3: retry_limit = 4'h8;
      2'h2: retry_limit = 4'h4;
      2'h1: retry_limit = 4'h2;
      default: retry_limit = 4'h1;
    endcase
  endfunction

  function automatic logic known_addr(input logic [31:0] a);
    known_addr = (a == `ADDR_CONFIG_TWO) || (a == `ADDR_RX_ERR_COUNT) || (a == `ADDR_SELF_TEST);
  endfunction

  // One wait state: answer in the second access cycle
  assign wr_fire = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_fire = psel_i && penable_i && !pready_o && !pwrite_i;
  assign bad_addr = !known_addr(paddr_i);
  assign fail_limit = retry_limit(downshift_retry_count_reg);

  assign cfg_view = {2'h0, int_active_low_reg, 1'b0, downshift_retry_count_reg, downshift_enable_reg,
    downshift_energy_mode_reg, 1'b0, downshift_to_ten_enable_reg, `CFG_LOW_PATTERN};

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      pready_o <= 1'b0;
    else
      pready_o <= psel_i && penable_i && !pready_o;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (psel_i && penable_i && !pready_o)
    begin
      pslverr_o <= bad_addr;
      prdata_o <= 32'h0000_0000;
      if (rd_fire)
      begin
        if (paddr_i == `ADDR_CONFIG_TWO)
          prdata_o <= {16'h0000, cfg_view};
        else if (paddr_i == `ADDR_RX_ERR_COUNT)
          prdata_o <= {16'h0000, receive_error_tally_reg};
        else if (paddr_i == `ADDR_SELF_TEST)
          prdata_o <= {16'h0000, self_test_reg & `ST_WRITE_MASK};
      end
    end
    else
      pslverr_o <= 1'b0;
  end

  // Configuration register; strap caught on first cycle after reset
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      int_active_low_reg <= 1'b1;
      downshift_retry_count_reg <= `CFG_RETRY_RESET;
      downshift_enable_reg <= 1'b0;
      downshift_energy_mode_reg <= 1'b1;
      downshift_to_ten_enable_reg <= 1'b1;
      strap_taken_reg <= 1'b0;
    end
    else
    begin
      strap_taken_reg <= 1'b1;
      if (!strap_taken_reg && LARGE_PACKAGE)
        downshift_enable_reg <= downshift_strap_i;
      if (wr_fire && paddr_i == `ADDR_CONFIG_TWO)
      begin
        if (pstrb_i[1])
        begin
          int_active_low_reg <= pwdata_i[`CFG_INT_POL_BIT];
          downshift_enable_reg <= pwdata_i[`CFG_DS_EN_BIT];
          downshift_energy_mode_reg <= pwdata_i[`CFG_ENERGY_BIT];
        end
        if (pstrb_i[0])
          downshift_to_ten_enable_reg <= pwdata_i[`CFG_TEN_BIT];
      end
    end
  end

  // Error tally: the clearing write wins over a same-cycle event
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      receive_error_tally_reg <= 16'h0000;
    else if (wr_fire && paddr_i == `ADDR_RX_ERR_COUNT)
      receive_error_tally_reg <= 16'h0000;
    else if (rx_error_event_i && receive_error_tally_reg != `ERR_TALLY_MAX)
      receive_error_tally_reg <= receive_error_tally_reg + 16'h0001;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      self_test_reg <= 16'h0000;
    else if (wr_fire && paddr_i == `ADDR_SELF_TEST)
    begin
      if (pstrb_i[1])
        self_test_reg[15:8] <= pwdata_i[15:8] & 8'(`ST_WRITE_MASK >> 8);
      if (pstrb_i[0])
        self_test_reg[7:0] <= pwdata_i[7:0];
    end
  end

  // Downshift policy
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      fail_cnt_reg <= 4'h0;
      downshift_to_fast_o <= 1'b0;
      downshift_to_ten_o <= 1'b0;
    end
    else if (!downshift_enable_reg)
    begin
      fail_cnt_reg <= 4'h0;
      downshift_to_fast_o <= 1'b0;
      downshift_to_ten_o <= 1'b0;
    end
    else
    begin
      if (gig_attempt_fail_i && fail_cnt_reg < fail_limit)
        fail_cnt_reg <= fail_cnt_reg + 4'h1;
      if ((gig_attempt_fail_i && fail_cnt_reg + 4'h1 >= fail_limit) ||
          (downshift_energy_mode_reg && energy_cd_absent_i))
        downshift_to_fast_o <= 1'b1;
      if (downshift_to_ten_enable_reg && downshift_to_fast_o && fast_attempt_fail_i)
        downshift_to_ten_o <= 1'b1;
    end
  end

  frame_generator #(
    .CNT_W(16)
  ) u_gen (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .enable_i(self_test_reg[`ST_GEN_EN_BIT]),
    .payload_prbs_i(self_test_reg[`ST_PAYLOAD_BIT]),
    .short_i(self_test_reg[`ST_SHORT_BIT]),
    .wrap_mode_i(self_test_reg[`ST_WRAP_BIT]),
    .byte_ready_i(frame_ready_i),
    .byte_valid_o(gen_valid),
    .byte_data_o(gen_data),
    .busy_o(gen_busy),
    .wrap_pulse_o(gen_wrap)
  );

  // Registered outputs
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      int_pin_o <= 1'b1;
      frame_valid_o <= 1'b0;
      frame_data_o <= 8'h00;
      generator_busy_o <= 1'b0;
      prbs_checker_on_o <= 1'b0;
      prbs_wrap_pulse_o <= 1'b0;
      loop_point_o <= 4'h0;
      coding_point_o <= CODE_OFF;
      rx_to_mac_o <= 1'b1;
      tx_to_line_o <= 1'b0;
    end
    else
    begin
      int_pin_o <= event_pending_i ^ int_active_low_reg;
      frame_valid_o <= gen_valid;
      frame_data_o <= gen_data;
      generator_busy_o <= gen_busy;
      prbs_checker_on_o <= self_test_reg[`ST_PAYLOAD_BIT];
      prbs_wrap_pulse_o <= gen_wrap;
      case (self_test_reg[`ST_LOOP_HI:`ST_LOOP_LO])
        `LOOP_REVERSE, `LOOP_EXTERNAL, `LOOP_ANALOG, `LOOP_DIGITAL:
          loop_point_o <= self_test_reg[`ST_LOOP_HI:`ST_LOOP_LO];
        default: loop_point_o <= 4'h0;
      endcase
      rx_to_mac_o <= !(loop_active_i && self_test_reg[`ST_LOOP_HI:`ST_LOOP_LO] == `LOOP_REVERSE &&
        !self_test_reg[`ST_FAR_FWD_BIT]);
      tx_to_line_o <= loop_active_i && self_test_reg[`ST_MII_FWD_BIT];
      if (link_speed_i == SPEED_1000)
        coding_point_o <= self_test_reg[`ST_CODING_LO] ? CODE_GIG_EARLY : CODE_OFF;
      else
      begin
        case (self_test_reg[`ST_CODING_HI:`ST_CODING_LO])
          2'h3: coding_point_o <= CODE_AFTER_MLT3;
          2'h2: coding_point_o <= CODE_AFTER_SCR;
          2'h1: coding_point_o <= CODE_BEFORE_SCR;
          default: coding_point_o <= CODE_OFF;
        endcase
      end
    end
  end

  AST_TALLY_SATURATES: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    receive_error_tally_reg == `ERR_TALLY_MAX && !wr_fire |=> receive_error_tally_reg == `ERR_TALLY_MAX)
    else $error("error tally wrapped");
  AST_TALLY_CLEARS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_fire && paddr_i == `ADDR_RX_ERR_COUNT |=> receive_error_tally_reg == 16'h0000)
    else $error("error tally not cleared");
  AST_INT_POLARITY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $stable(int_active_low_reg) |=> int_pin_o == ($past(event_pending_i) ^ $past(int_active_low_reg)))
    else $error("interrupt polarity wrong");
  AST_GEN_STOPS: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !self_test_reg[`ST_GEN_EN_BIT] [*3] |-> !frame_valid_o)
    else $error("generator runs while disabled");
  AST_NO_DOWNSHIFT_DISABLED: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !downshift_enable_reg |=> !downshift_to_fast_o && !downshift_to_ten_o)
    else $error("downshift while disabled");
  AST_TEN_NEEDS_ENABLE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(downshift_to_ten_o) |-> $past(downshift_to_ten_enable_reg))
    else $error("ten-megabit downshift while off");
  AST_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pready_o && !pwrite_i && paddr_i == `ADDR_SELF_TEST |-> prdata_o[11:8] == 4'h0)
    else $error("reserved bits read nonzero");
  AST_FORWARD_TO_LINE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !loop_active_i |=> !tx_to_line_o)
    else $error("line forward outside loop");
endmodule // phy_config_bist_registers

// ===== frame_sink.sv
`timescale 1ns/1ps
module frame_sink (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic valid_i,
  input wire logic stall_i,
  output logic ready_o,
  output int count_o
);
  logic [1:0] phase_reg;
  logic took_reg;
  // Slow mode drops ready one cycle in three
  assign ready_o = !(stall_i && phase_reg == 2'h0);
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      phase_reg <= 2'h0;
      took_reg <= 1'b0;
      count_o <= 0;
    end
    else
    begin
      phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
      took_reg <= ready_o;
      // The byte shows on the pins one cycle after the generator took ready
      if (valid_i && took_reg)
      begin
        count_o <= count_o + 1;
      end
    end
  end
endmodule // frame_sink

// ===== test_phy_config_bist_registers.sv
`timescale 1ns/1ps
`include "phy_cfg_map.svh"
module test_phy_config_bist_registers;
  logic mclk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, ev = 0, rxe = 0, gf = 0, ff = 0, nrg = 0;
  logic lact = 0, stall = 0, rdy, serr, intp, dfast, dten, fv, busy, chk_on, wrp, r2m, t2l, fr;
  logic [31:0] pa = 0, pd = 0, prd, rd;
  logic [1:0] spd = 0;
  logic [3:0] lp;
  logic [2:0] cp;
  logic [7:0] fd;
  logic se;
  int fails = 0, tests_run = 0, nb;

  initial forever #2.5 mclk_i = ~mclk_i;

  phy_config_bist_registers u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pd), .pstrb_i(4'hf), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(serr), .downshift_strap_i(1'b0), .event_pending_i(ev), .rx_error_event_i(rxe),
    .gig_attempt_fail_i(gf), .fast_attempt_fail_i(ff), .energy_cd_absent_i(nrg), .link_speed_i(spd),
    .loop_active_i(lact), .frame_ready_i(fr), .int_pin_o(intp), .downshift_to_fast_o(dfast),
    .downshift_to_ten_o(dten), .frame_valid_o(fv), .frame_data_o(fd), .generator_busy_o(busy),
    .prbs_checker_on_o(chk_on), .prbs_wrap_pulse_o(wrp), .loop_point_o(lp), .coding_point_o(cp),
    .rx_to_mac_o(r2m), .tx_to_line_o(t2l));

  frame_sink u_sink (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .valid_i(fv), .stall_i(stall), .ready_o(fr),
    .count_o(nb));

  task automatic print_verdict;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pd <= d;
    @(posedge mclk_i);
    pen <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (rdy !== 1'b1 && n < 50);
    if (n >= 50)
      check(0, 1, "apb hang");
    rd = prd;
    se = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp, "read");
  endtask

  task automatic reset_dut;
    rst_n_i <= 1'b0;
    wt(4);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
  endtask

  task automatic t_reset;
    rdc(`ADDR_CONFIG_TWO, 32'h0000_2947);
    rdc(`ADDR_RX_ERR_COUNT, 32'h0);
    rdc(`ADDR_SELF_TEST, 32'h0);
    check(intp, 1'b1, "idle pin");
    rdc(32'h0000_005c, 32'h0);
    check(se, 1'b1, "unmapped");
  endtask

  task automatic t_cfg;
    apb(1'b1, `ADDR_CONFIG_TWO, 32'hffff_ffff);
    rdc(`ADDR_CONFIG_TWO, 32'h0000_2b47);
    ev <= 1'b1;
    wt(3);
    check(intp, 1'b0, "low active");
    apb(1'b1, `ADDR_CONFIG_TWO, 32'h0);
    rdc(`ADDR_CONFIG_TWO, 32'h0000_0807);
    wt(2);
    check(intp, 1'b1, "high active");
    ev <= 1'b0;
    wt(3);
    check(intp, 1'b0, "high idle");
  endtask

  task automatic t_tally;
    rxe <= 1'b1;
    wt(5);
    rxe <= 1'b0;
    wt(1);
    rdc(`ADDR_RX_ERR_COUNT, 32'h5);
    apb(1'b1, `ADDR_RX_ERR_COUNT, 32'h1234);
    rdc(`ADDR_RX_ERR_COUNT, 32'h0);
    rxe <= 1'b1;
    wt(65540);
    rxe <= 1'b0;
    wt(1);
    rdc(`ADDR_RX_ERR_COUNT, 32'hffff);
  endtask

  task automatic t_loop;
    apb(1'b1, `ADDR_SELF_TEST, 32'hffff_0f00);
    rdc(`ADDR_SELF_TEST, 32'h0);
    spd <= 2'h1;
    for (int c = 1; c < 4; c++)
    begin
      apb(1'b1, `ADDR_SELF_TEST, c);
      wt(2);
      check(cp, c, "fast coding");
    end
    spd <= 2'h2;
    apb(1'b1, `ADDR_SELF_TEST, 32'h2);
    wt(2);
    check(cp, 3'h2, "ten coding");
    spd <= 2'h0;
    apb(1'b1, `ADDR_SELF_TEST, 32'h3);
    wt(2);
    check(cp, 3'h4, "gig coding");
    apb(1'b1, `ADDR_SELF_TEST, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `ADDR_SELF_TEST, 32'h4 << i);
      wt(2);
      check(lp, 4'h1 << i, "loop point");
    end
    apb(1'b1, `ADDR_SELF_TEST, 32'h0c);
    wt(2);
    check(lp, 4'h0, "not one-hot");
    lact <= 1'b1;
    apb(1'b1, `ADDR_SELF_TEST, 32'h20);
    wt(2);
    check(r2m, 1'b0, "rev hold");
    apb(1'b1, `ADDR_SELF_TEST, 32'ha0);
    wt(2);
    check(r2m, 1'b1, "rev fwd");
    check(t2l, 1'b0, "line held");
    apb(1'b1, `ADDR_SELF_TEST, 32'h04);
    apb(1'b1, `ADDR_SELF_TEST, 32'h44);
    wt(2);
    check(t2l, 1'b1, "line fwd");
    apb(1'b1, `ADDR_SELF_TEST, 32'h04);
    wt(2);
    check(t2l, 1'b0, "line off");
    apb(1'b1, `ADDR_SELF_TEST, 32'h0);
    lact <= 1'b0;
  endtask

  task automatic t_gen(input logic [31:0] d, input int exp);
    int n0;
    logic [7:0] d0;
    n0 = nb;
    apb(1'b1, `ADDR_SELF_TEST, d);
    wt(40);
    check(busy, 1'b1, "busy");
    d0 = fd;
    wt(10);
    check(fd, d0, "constant data");
    wt(2990);
    check(nb - n0, exp, "frame bytes");
    check(chk_on, 1'b0, "checker off");
    apb(1'b1, `ADDR_SELF_TEST, 32'h0);
  endtask

  task automatic t_prbs;
    int n0;
    n0 = nb;
    apb(1'b1, `ADDR_SELF_TEST, 32'hf000);
    wt(400);
    check(busy, 1'b1, "prbs run");
    check(nb - n0 > 200, 1'b1, "prbs stream");
    check(wrp, 1'b0, "no early wrap");
    apb(1'b1, `ADDR_SELF_TEST, 32'hc000);
    wt(200);
    n0 = nb;
    wt(50);
    check(nb, n0, "gen stopped");
    check(chk_on, 1'b1, "checker kept");
    apb(1'b1, `ADDR_SELF_TEST, 32'h0);
  endtask

  task automatic pulse(input bit gig, input int n);
    repeat (n)
    begin
      if (gig)
        gf <= 1'b1;
      else
        ff <= 1'b1;
      @(posedge mclk_i);
      gf <= 1'b0;
      ff <= 1'b0;
      @(posedge mclk_i);
    end
    wt(3);
  endtask

  task automatic t_down;
    reset_dut();
    apb(1'b1, `ADDR_CONFIG_TWO, 32'h2240);
    pulse(1, 3);
    check(dfast, 1'b0, "early shift");
    pulse(1, 1);
    check(dfast, 1'b1, "shift fast");
    pulse(0, 1);
    check(dten, 1'b1, "shift ten");
    reset_dut();
    apb(1'b1, `ADDR_CONFIG_TWO, 32'h2040);
    pulse(1, 8);
    check(dfast, 1'b0, "shift disabled");
    reset_dut();
    apb(1'b1, `ADDR_CONFIG_TWO, 32'h2300);
    nrg <= 1'b1;
    wt(4);
    check(dfast, 1'b1, "energy shift");
    pulse(0, 1);
    check(dten, 1'b0, "ten blocked");
    nrg <= 1'b0;
  endtask

  initial
  begin
    #420_000;
    fails++;
    print_verdict();
  end

  initial
  begin
    reset_dut();
    t_reset();
    t_cfg();
    t_tally();
    t_loop();
    stall <= 1'b1;
    t_gen(32'hb000, 64);
    t_gen(32'h9000, 1518);
    t_prbs();
    t_down();
    print_verdict();
  end
endmodule // test_phy_config_bist_registers
